/* File: stm_timer.sv */
// standard timer: compare, pwm, single pulse, capture and timer modes
//
// The placing of the registers and strobed register access were decided locally.
`timescale 1ns/1ps
module stm_timer #(
  parameter int CNT_W = stm_pkg::CNT_W
) (
  // clock and reset
  input  wire logic             clk_sys,
  input  wire logic             rst,
  // register port
  input  wire logic [2:0]       reg_addr,
  input  wire logic [15:0]      reg_wdata,
  input  wire logic             reg_wr,
  input  wire logic             reg_rd,
  output logic      [15:0]      reg_rdata,
  // pins
  input  wire logic             external_trigger_pin,
  input  wire logic             capture_input_pin,
  output logic                  timer_out,
  output logic                  timer_out_oe_n,
  // events
  output logic                  compare_a_flag,
  output logic                  compare_p_flag,
  output logic                  timer_event
);
  logic [7:0]       ctrl1_r, ctrl1_nxt;
  logic             run_r, run_nxt;
  logic [1:0]       cksel_r, cksel_nxt;
  logic [CNT_W-1:0] cnt_r, cnt_nxt;
  logic [CNT_W-1:0] cmpa_r, cmpa_nxt;
  logic [CNT_W-1:0] cmpp_r, cmpp_nxt;
  logic             fa_r, fa_nxt;
  logic             fp_r, fp_nxt;
  logic             pin_r, pin_nxt;
  logic             run_d_r;
  logic             out_r, out_nxt;
  logic             oe_n_r, oe_n_nxt;
  logic             evt_r, evt_nxt;
  logic [15:0]      rdata_nxt;
  logic             tick;
  logic             trig_rise, trig_fall, cap_rise, cap_fall;
  logic             trig_lvl, cap_lvl;

  stm_pkg::stm_mode_type mode;
  logic [1:0]       act;
  logic             cclr, dpx, pol, oc;
  logic             run_rise;
  logic             is_cmp, is_pwm, is_sp;
  logic             hit_a, hit_p;
  logic [CNT_W:0]   p_len, a_len, period_len, duty_len;
  logic             cap_edge;

  assign mode = stm_pkg::stm_mode_type'(ctrl1_r[stm_pkg::POS_MODE +: 2]);
  assign act  = ctrl1_r[stm_pkg::POS_IO +: 2];
  assign cclr = ctrl1_r[stm_pkg::POS_CCLR];
  assign dpx  = ctrl1_r[stm_pkg::POS_DPX];
  assign pol  = ctrl1_r[stm_pkg::POS_POL];
  assign oc   = ctrl1_r[stm_pkg::POS_OC];

  stm_prescale u_pre (
    .clk_sys (clk_sys),
    .rst     (rst),
    .sel     (cksel_r),
    .tick    (tick)
  );

  stm_pin_sync u_trig (
    .clk_sys (clk_sys),
    .rst     (rst),
    .pin     (external_trigger_pin),
    .level   (trig_lvl),
    .rise    (trig_rise),
    .fall    (trig_fall)
  );

  stm_pin_sync u_cap (
    .clk_sys (clk_sys),
    .rst     (rst),
    .pin     (capture_input_pin),
    .level   (cap_lvl),
    .rise    (cap_rise),
    .fall    (cap_fall)
  );

  // 3-bit P code as a length in timer clocks
  function automatic logic [CNT_W:0] p_length(input logic [CNT_W-1:0] v);
    logic [2:0] code;
    code = v[CNT_W-1 -: 3];
    p_length = (code == 3'h0) ? (CNT_W+1)'(1 << CNT_W)
                              : (CNT_W+1)'({code, 7'h00});
  endfunction

  // full compare value as a length, zero meaning full range
  function automatic logic [CNT_W:0] full_length(input logic [CNT_W-1:0] v);
    full_length = (v == '0) ? (CNT_W+1)'(1 << CNT_W) : {1'b0, v};
  endfunction

  assign run_rise = run_r & ~run_d_r;
  assign is_cmp   = (mode == stm_pkg::MODE_CMP) || (mode == stm_pkg::MODE_TMR);
  assign is_pwm   = (mode == stm_pkg::MODE_PWM) && (act != 2'h3);
  assign is_sp    = (mode == stm_pkg::MODE_PWM) && (act == 2'h3);
  assign p_len    = p_length(cmpp_r);
  assign a_len    = full_length(cmpa_r);
  assign period_len = dpx ? a_len : p_len;
  assign duty_len   = dpx ? p_len : a_len;
  // P compares on the upper three bits against the count after increment
  assign hit_p = tick && run_r && ({1'b0, cnt_r} + 1'b1 == p_len);
  assign hit_a = tick && run_r && (cmpa_r != '0) && (cnt_r + 1'b1 == cmpa_r);
  // capture needs edge select from the action field
  always_comb
  begin
    unique case (act)
      2'h0:    cap_edge = cap_rise;
      2'h1:    cap_edge = cap_fall;
      2'h2:    cap_edge = cap_rise | cap_fall;
      default: cap_edge = 1'b0;
    endcase
  end

  // registers and counter next state
  always_comb
  begin
    ctrl1_nxt = ctrl1_r;
    run_nxt   = run_r;
    cksel_nxt = cksel_r;
    cmpa_nxt  = cmpa_r;
    cmpp_nxt  = cmpp_r;
    cnt_nxt   = cnt_r;
    fa_nxt    = fa_r;
    fp_nxt    = fp_r;
    evt_nxt   = 1'b0;
    if (reg_wr)
    begin
      unique case (reg_addr)
        stm_pkg::ADDR_CTRL0:
        begin
          run_nxt   = reg_wdata[stm_pkg::POS_RUN];
          cksel_nxt = reg_wdata[stm_pkg::POS_CKSEL +: 2];
        end
        stm_pkg::ADDR_CTRL1: ctrl1_nxt = reg_wdata[7:0];
        stm_pkg::ADDR_CMPA:  cmpa_nxt  = reg_wdata[CNT_W-1:0];
        stm_pkg::ADDR_CMPP:  cmpp_nxt  = reg_wdata[CNT_W-1:0];
        stm_pkg::ADDR_FLAGS:
        begin
          if (reg_wdata[stm_pkg::POS_FA]) fa_nxt = 1'b0;
          if (reg_wdata[stm_pkg::POS_FP]) fp_nxt = 1'b0;
        end
        default: ;
      endcase
    end
    if (is_sp && trig_rise)
      run_nxt = 1'b1;
    if (run_rise)
      cnt_nxt = '0;
    else if (tick && run_r)
    begin
      if (is_cmp)
      begin
        if (cclr ? hit_a : (cmpp_r == '0 ? cnt_r == stm_pkg::CNT_MAX : hit_p))
          cnt_nxt = '0;
        else
          cnt_nxt = cnt_r + 1'b1;
        if (hit_a)
          fa_nxt = 1'b1;
        if (!cclr && (hit_p || (cmpp_r == '0 && cnt_r == stm_pkg::CNT_MAX)))
          fp_nxt = 1'b1;
        evt_nxt = hit_a || (!cclr && hit_p);
      end
      else if (is_pwm)
      begin
        cnt_nxt = ({1'b0, cnt_r} + 1'b1 >= period_len) ? '0 : cnt_r + 1'b1;
        if (hit_a)
          fa_nxt = 1'b1;
        if (hit_p)
          fp_nxt = 1'b1;
        evt_nxt = hit_a | hit_p;
      end
      else if (is_sp)
      begin
        cnt_nxt = cnt_r + 1'b1;
        if (hit_a)
        begin
          fa_nxt  = 1'b1;
          run_nxt = 1'b0;
          evt_nxt = 1'b1;
        end
      end
      else
      begin
        // capture: wraps on P, P zero lets it reach the top
        cnt_nxt = (cmpp_r != '0 && cnt_r + 1'b1 == cmpp_r) ? '0 : cnt_r + 1'b1;
        if (cmpp_r != '0 && cnt_r + 1'b1 == cmpp_r)
        begin
          fp_nxt  = 1'b1;
          evt_nxt = 1'b1;
        end
      end
    end
    if ((mode == stm_pkg::MODE_CAP) && run_r && cap_edge)
    begin
      cmpa_nxt = cnt_r;
      fa_nxt   = 1'b1;
      evt_nxt  = 1'b1;
    end
  end

  // output pin level; sets win over software clears above
  always_comb
  begin
    pin_nxt  = pin_r;
    oe_n_nxt = 1'b0;
    if (run_rise)
      pin_nxt = oc;
    else if (is_cmp && hit_a)
    begin
      unique case (act)
        2'h1:    pin_nxt = 1'b1;
        2'h2:    pin_nxt = 1'b0;
        2'h3:    pin_nxt = ~pin_r;
        default: pin_nxt = pin_r;
      endcase
    end
    else if (is_sp && !run_r)
      pin_nxt = ~oc;
    if (is_pwm)
    begin
      unique case (act)
        2'h0:    out_nxt = 1'b0;
        2'h1:    out_nxt = 1'b1;
        default: out_nxt = (oc ? ({1'b0, cnt_r} < duty_len || duty_len >= period_len)
                               : !({1'b0, cnt_r} < duty_len || duty_len >= period_len)) ^ pol;
      endcase
    end
    else if (is_sp)
      out_nxt = (run_r ? oc : ~oc) ^ pol;
    else
      out_nxt = pin_r ^ pol;
    if (mode == stm_pkg::MODE_TMR || mode == stm_pkg::MODE_CAP)
    begin
      oe_n_nxt = 1'b1;
      out_nxt  = 1'b0;
    end
  end

  always_comb
  begin
    rdata_nxt = 16'h0000;
    if (reg_rd)
    begin
      unique case (reg_addr)
        stm_pkg::ADDR_CTRL0:  rdata_nxt = {12'h000, run_r, 1'b0, cksel_r};
        stm_pkg::ADDR_CTRL1:  rdata_nxt = {8'h00, ctrl1_r};
        stm_pkg::ADDR_CNT:    rdata_nxt = {6'h00, cnt_r};
        stm_pkg::ADDR_CMPA:   rdata_nxt = {6'h00, cmpa_r};
        stm_pkg::ADDR_CMPP:   rdata_nxt = {6'h00, cmpp_r};
        stm_pkg::ADDR_FLAGS:  rdata_nxt = {14'h0000, fp_r, fa_r};
        default:              rdata_nxt = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      ctrl1_r   <= stm_pkg::CTRL1_RST;
      run_r     <= 1'b0;
      run_d_r   <= 1'b0;
      cksel_r   <= stm_pkg::PRE_DIV1;
      cnt_r     <= '0;
      cmpa_r    <= stm_pkg::CMP_RST;
      cmpp_r    <= stm_pkg::CMP_RST;
      fa_r      <= 1'b0;
      fp_r      <= 1'b0;
      pin_r     <= 1'b0;
      out_r     <= 1'b0;
      oe_n_r    <= 1'b1;
      evt_r     <= 1'b0;
      reg_rdata <= 16'h0000;
    end
    else
    begin
      ctrl1_r   <= ctrl1_nxt;
      run_r     <= run_nxt;
      run_d_r   <= run_r;
      cksel_r   <= cksel_nxt;
      cnt_r     <= cnt_nxt;
      cmpa_r    <= cmpa_nxt;
      cmpp_r    <= cmpp_nxt;
      fa_r      <= fa_nxt;
      fp_r      <= fp_nxt;
      pin_r     <= pin_nxt;
      out_r     <= out_nxt;
      oe_n_r    <= oe_n_nxt;
      evt_r     <= evt_nxt;
      reg_rdata <= rdata_nxt;
    end
  end

  assign timer_out      = out_r;
  assign timer_out_oe_n = oe_n_r;
  assign compare_a_flag = fa_r;
  assign compare_p_flag = fp_r;
  assign timer_event    = evt_r;

  a_no_p_flag_clra: assert property (@(posedge clk_sys) disable iff (rst)
    (is_cmp && cclr && !fp_r) |=> !fp_r)
    else $error("compare p flag set while clearing on a");

  a_tmr_pin_off: assert property (@(posedge clk_sys) disable iff (rst)
    (mode == stm_pkg::MODE_TMR) |=> timer_out_oe_n)
    else $error("output driven in timer mode");

  a_run_rise_load: assert property (@(posedge clk_sys) disable iff (rst)
    run_rise |=> (pin_r == $past(oc)))
    else $error("pin not reloaded on run rise");

  a_sp_stop_on_a: assert property (@(posedge clk_sys) disable iff (rst)
    (is_sp && hit_a && !reg_wr && !trig_rise) |=> !run_r)
    else $error("single pulse not stopped on a match");

  a_trig_start: assert property (@(posedge clk_sys) disable iff (rst)
    (is_sp && trig_rise) |=> run_r)
    else $error("trigger did not start pulse");

  a_cap_copy: assert property (@(posedge clk_sys) disable iff (rst)
    ((mode == stm_pkg::MODE_CAP) && run_r && cap_edge) |=> (cmpa_r == $past(cnt_r)) && fa_r)
    else $error("capture did not copy counter");

  a_cnt_zero_start: assert property (@(posedge clk_sys) disable iff (rst)
    run_rise |=> (cnt_r == '0))
    else $error("counter not zeroed on start");

  a_cap_off_oe: assert property (@(posedge clk_sys) disable iff (rst)
    (mode == stm_pkg::MODE_CAP) |=> timer_out_oe_n && !timer_out)
    else $error("output driven in capture mode");
endmodule

/* File: stm_pkg.sv */
// constants and types shared by the standard timer block
package stm_pkg;
  localparam int CNT_W = 10;
  // register indices on the plain register port
  localparam logic [2:0] ADDR_CTRL0  = 3'h0;
  localparam logic [2:0] ADDR_CTRL1  = 3'h1;
  localparam logic [2:0] ADDR_CNT    = 3'h2;
  localparam logic [2:0] ADDR_CMPA   = 3'h3;
  localparam logic [2:0] ADDR_CMPP   = 3'h4;
  localparam logic [2:0] ADDR_FLAGS  = 3'h5;
  // control-one field positions
  localparam int POS_CCLR  = 0;
  localparam int POS_DPX   = 1;
  localparam int POS_POL   = 2;
  localparam int POS_OC    = 3;
  localparam int POS_IO    = 4;
  localparam int POS_MODE  = 6;
  // control-zero field positions
  localparam int POS_RUN   = 3;
  localparam int POS_CKSEL = 0;
  // flag register positions
  localparam int POS_FA    = 0;
  localparam int POS_FP    = 1;
  // reset values and the counter maximum
  localparam logic [7:0]       CTRL1_RST = 8'h00;
  localparam logic [CNT_W-1:0] CMP_RST   = 10'h000;
  localparam logic [CNT_W-1:0] CNT_MAX   = 10'h3FF;
  // compare p selects multiples of this step
  localparam int P_STEP_SHIFT = 7;
  // timer clock prescale choices, in system clocks
  localparam logic [1:0] PRE_DIV1  = 2'h0;
  localparam logic [1:0] PRE_DIV4  = 2'h1;
  localparam logic [1:0] PRE_DIV16 = 2'h2;
  localparam logic [1:0] PRE_DIV64 = 2'h3;
  typedef enum logic [1:0] {
    MODE_CMP  = 2'h0,
    MODE_CAP  = 2'h1,
    MODE_PWM  = 2'h2,
    MODE_TMR  = 2'h3
  } stm_mode_type;
endpackage

/* File: stm_prescale.sv */
// timer clock enable divider
`timescale 1ns/1ps
module stm_prescale (
  // clock and reset
  input  wire logic       clk_sys,
  input  wire logic       rst,
  // selection and enable out
  input  wire logic [1:0] sel,
  output logic            tick
);
  logic [5:0] cnt_r;
  logic [5:0] cnt_nxt;
  logic       tick_nxt;

  always_comb
  begin
    cnt_nxt  = cnt_r + 6'h01;
    tick_nxt = 1'b0;
    unique case (sel)
      stm_pkg::PRE_DIV1:  tick_nxt = 1'b1;
      stm_pkg::PRE_DIV4:  tick_nxt = (cnt_r[1:0] == 2'h3);
      stm_pkg::PRE_DIV16: tick_nxt = (cnt_r[3:0] == 4'hF);
      stm_pkg::PRE_DIV64: tick_nxt = (cnt_r == 6'h3F);
    endcase
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      cnt_r <= 6'h00;
      tick  <= 1'b0;
    end
    else
    begin
      cnt_r <= cnt_nxt;
      tick  <= tick_nxt;
    end
  end
endmodule

/* File: stm_pin_sync.sv */
// three-stage pin synchroniser with edge detection
`timescale 1ns/1ps
module stm_pin_sync (
  // clock and reset
  input  wire logic clk_sys,
  input  wire logic rst,
  // pin in, edges out
  input  wire logic pin,
  output logic      level,
  output logic      rise,
  output logic      fall
);
  logic [2:0] sh_r;
  logic [2:0] sh_nxt;
  logic       lvl_r;
  logic       lvl_nxt;

  // a change counts once stages two and three agree
  always_comb
  begin
    sh_nxt  = {sh_r[1:0], pin};
    lvl_nxt = (sh_r[2] == sh_r[1]) ? sh_r[2] : lvl_r;
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      sh_r  <= 3'h0;
      lvl_r <= 1'b0;
    end
    else
    begin
      sh_r  <= sh_nxt;
      lvl_r <= lvl_nxt;
    end
  end

  assign level = lvl_r;
  assign rise  = lvl_nxt & ~lvl_r;
  assign fall  = ~lvl_nxt & lvl_r;
endmodule

/* File: stm_far_side.sv */
// far side of the timer pins: trigger source, capture source and output pin load
`timescale 1ns/1ps
module stm_far_side (
  // clock
  input  wire logic clk_sys,
  // pins toward the timer
  output logic      external_trigger_pin,
  output logic      capture_input_pin,
  // output pin and its load
  input  wire logic timer_out,
  input  wire logic timer_out_oe_n,
  output logic      pin_level
);
  // pull-up keeps the released pin high
  assign pin_level = timer_out_oe_n ? 1'b1 : timer_out;
  initial
  begin
    external_trigger_pin = 1'b0;
    capture_input_pin    = 1'b0;
  end
  // held for several clocks so the synchroniser sees it
  task automatic pulse_trigger();
    @(posedge clk_sys);
    external_trigger_pin <= 1'b1;
    repeat (6) @(posedge clk_sys);
    external_trigger_pin <= 1'b0;
  endtask
  task automatic drive_capture(input logic lvl);
    @(posedge clk_sys);
    capture_input_pin <= lvl;
  endtask
endmodule

/* File: tb.sv */
// self-checking bench of the standard timer
`timescale 1ns/1ps
module tb;
  logic        clk_sys;
  logic        rst;
  logic [2:0]  reg_addr;
  logic [15:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [15:0] reg_rdata;
  logic        external_trigger_pin;
  logic        capture_input_pin;
  logic        timer_out;
  logic        timer_out_oe_n;
  logic        compare_a_flag;
  logic        compare_p_flag;
  logic        timer_event;
  logic        pin_level;
  int          miscompares;
  int          total_checks;
  int          events;
  logic [15:0] v;
  stm_timer stm_timer_inst (
    .clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .external_trigger_pin(external_trigger_pin), .capture_input_pin(capture_input_pin),
    .timer_out(timer_out), .timer_out_oe_n(timer_out_oe_n),
    .compare_a_flag(compare_a_flag), .compare_p_flag(compare_p_flag), .timer_event(timer_event)
  );
  stm_far_side stm_far_side_inst (
    .clk_sys(clk_sys), .external_trigger_pin(external_trigger_pin),
    .capture_input_pin(capture_input_pin), .timer_out(timer_out),
    .timer_out_oe_n(timer_out_oe_n), .pin_level(pin_level)
  );
  initial
  begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys)
    if (timer_event === 1'b1) events++;
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk_sys);
    reg_wr    <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a, output logic [15:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk_sys);
    reg_rd   <= 1'b0;
    #1 d = reg_rdata;
  endtask
  function automatic logic [15:0] c1(input logic [1:0] m, input logic [1:0] io, input logic oc, input logic pol,
                                     input logic dpx, input logic clr);
    return {8'h00, m, io, oc, pol, dpx, clr};
  endfunction
  // stop, clear flags, program and restart with a fresh run rising edge
  task automatic start(input logic [15:0] ctl, input logic [15:0] a, input logic [15:0] p);
    wr(stm_pkg::ADDR_CTRL0, 16'h0000);
    wr(stm_pkg::ADDR_FLAGS, 16'h0003);
    wr(stm_pkg::ADDR_CTRL1, ctl);
    wr(stm_pkg::ADDR_CMPA, a);
    wr(stm_pkg::ADDR_CMPP, p);
    wr(stm_pkg::ADDR_CTRL0, 16'h0008);
  endtask
  task automatic t_reset_values();
    check("oe_n", {15'h0000, timer_out_oe_n}, 16'h0001);
    rd(stm_pkg::ADDR_CTRL1, v); check("ctrl1", v, 16'h0000);
    rd(stm_pkg::ADDR_CMPA, v);  check("cmpa", v, 16'h0000);
    wr(3'h6, 16'hFFFF);
    rd(3'h6, v);                check("unmapped", v, 16'h0000);
  endtask
  task automatic t_compare_hold(input logic pol);
    logic held;
    held = 1'b1;
    start(c1(2'h0, 2'h0, 1'b1, pol, 1'b0, 1'b0), 16'h0040, 16'h0000);
    repeat (3) @(posedge clk_sys);
    repeat (300)
    begin
      @(posedge clk_sys);
      #1 if (timer_out !== ~pol) held = 1'b0;
    end
    check("cmp pin held", {15'h0000, held}, 16'h0001);
    check("cmp oe_n", {15'h0000, timer_out_oe_n}, 16'h0000);
  endtask
  // pin actions on an A match: drive high, drive low, then toggle once per period
  task automatic t_compare_action();
    int   toggles;
    logic last;
    for (int i = 1; i < 3; i++)
    begin
      start(c1(2'h0, i[1:0], i == 2, 1'b0, 1'b0, 1'b0), 16'h0040, 16'h0080);
      repeat (20) @(posedge clk_sys);
      #1 check("cmp initial", {15'h0000, timer_out}, {15'h0000, i == 2});
      repeat (60) @(posedge clk_sys);
      #1 check("cmp action", {15'h0000, timer_out}, {15'h0000, i == 1});
    end
    start(c1(2'h0, 2'h3, 1'b0, 1'b0, 1'b0, 1'b0), 16'h0040, 16'h0080);
    repeat (3) @(posedge clk_sys);
    toggles = 0;
    #1 last = timer_out;
    repeat (512)
    begin
      @(posedge clk_sys);
      #1 if (timer_out !== last) toggles++;
      last = timer_out;
    end
    check("cmp toggles", toggles[15:0], 16'h0004);
  endtask
  task automatic t_timer_mode();
    start(c1(2'h3, 2'h2, 1'b1, 1'b0, 1'b0, 1'b0), 16'h0040, 16'h0080);
    repeat (300) @(posedge clk_sys);
    rd(stm_pkg::ADDR_FLAGS, v); check("tmr flags", v, 16'h0003);
    check("tmr flag pins", {14'h0000, compare_p_flag, compare_a_flag}, 16'h0003);
    check("tmr pin", {15'h0000, pin_level}, 16'h0001);
    start(c1(2'h3, 2'h0, 1'b0, 1'b0, 1'b0, 1'b1), 16'h0100, 16'h0080);
    repeat (600) @(posedge clk_sys);
    rd(stm_pkg::ADDR_FLAGS, v); check("clr a flags", v, 16'h0001);
    check("clr a flag pins", {14'h0000, compare_p_flag, compare_a_flag}, 16'h0001);
  endtask
  task automatic t_pwm(input logic [15:0] duty, input int exp_lo);
    int ones;
    int lo;
    ones = 0;
    start(c1(2'h2, 2'h2, 1'b1, 1'b0, 1'b0, 1'b1), duty, 16'h0080);
    repeat (140) @(posedge clk_sys);
    repeat (128)
    begin
      @(posedge clk_sys);
      #1 if (timer_out === 1'b1) ones++;
    end
    lo = (ones < 64) ? ones : 128 - ones;
    check("pwm duty", lo[15:0], exp_lo[15:0]);
    // a duty past the period of 128 is never reached, so no A match
    rd(stm_pkg::ADDR_FLAGS, v); check("pwm flags", v, (duty < 16'h0080) ? 16'h0003 : 16'h0002);
    check("pwm flag pins", {14'h0000, compare_p_flag, compare_a_flag}, v);
  endtask
  task automatic t_pwm_swap();
    int ones;
    ones = 0;
    start(c1(2'h2, 2'h2, 1'b1, 1'b0, 1'b1, 1'b0), 16'h0100, 16'h0080);
    repeat (300) @(posedge clk_sys);
    repeat (256)
    begin
      @(posedge clk_sys);
      #1 if (timer_out === 1'b1) ones++;
    end
    check("swap duty", ones[15:0], 16'h0080);
  endtask
  task automatic t_single_pulse();
    int ev0;
    start(c1(2'h2, 2'h3, 1'b1, 1'b0, 1'b0, 1'b0), 16'h0032, 16'h0000);
    wr(stm_pkg::ADDR_CTRL0, 16'h0000);
    wr(stm_pkg::ADDR_FLAGS, 16'h0003);
    ev0 = events;
    stm_far_side_inst.pulse_trigger();
    rd(stm_pkg::ADDR_CTRL0, v); check("sp run", v & 16'h0008, 16'h0008);
    check("sp lead", {15'h0000, timer_out}, 16'h0001);
    repeat (100) @(posedge clk_sys);
    rd(stm_pkg::ADDR_CTRL0, v); check("sp stop", v & 16'h0008, 16'h0000);
    rd(stm_pkg::ADDR_FLAGS, v); check("sp flag", v & 16'h0001, 16'h0001);
    check("sp trail", {15'h0000, timer_out}, 16'h0000);
    check("sp event", {15'h0000, events > ev0}, 16'h0001);
  endtask
  task automatic t_capture();
    logic [1:0] io;
    for (int i = 0; i < 4; i++)
    begin
      io = i[1:0];
      start(c1(2'h1, io, 1'b1, 1'b1, 1'b1, 1'b1), 16'h03FF, 16'h0080);
      repeat (20) @(posedge clk_sys);
      stm_far_side_inst.drive_capture(1'b1);
      repeat (20) @(posedge clk_sys);
      stm_far_side_inst.drive_capture(1'b0);
      repeat (20) @(posedge clk_sys);
      rd(stm_pkg::ADDR_CMPA, v);
      check("captured", {15'h0000, v !== 16'h03FF}, {15'h0000, io != 2'h3});
      check("cap pin", {15'h0000, pin_level}, 16'h0001);
    end
    // let the counter reach the P match at 128 after its last restart
    repeat (80) @(posedge clk_sys);
    rd(stm_pkg::ADDR_FLAGS, v); check("cap p flag", v & 16'h0002, 16'h0002);
  endtask
  task automatic print_verdict();
    if (miscompares == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial
  begin
    #2000000;
    miscompares++;
    print_verdict();
  end
  initial
  begin
    miscompares  = 0;
    total_checks = 0;
    events       = 0;
    rst          = 1'b1;
    reg_addr     = 3'h0;
    reg_wdata    = 16'h0000;
    reg_wr       = 1'b0;
    reg_rd       = 1'b0;
    repeat (12) @(posedge clk_sys);
    rst <= 1'b0;
    t_reset_values();
    t_compare_hold(1'b0);
    t_compare_hold(1'b1);
    t_compare_action();
    t_timer_mode();
    t_pwm(16'h0020, 32);
    t_pwm(16'h00C8, 0);
    t_pwm_swap();
    t_single_pulse();
    t_capture();
    print_verdict();
  end
endmodule
